// ### rtl/ocp_pkg.sv
// Shared constants for the two-wire character display port.
// Assumes a 100 MHz system clock on both ends of the link.
package ocp_pkg;
   // ==========================================================
   // Link addressing and control byte
   localparam logic [6:0] TGT_ADDR_LO = 7'h3C;
   localparam logic [6:0] TGT_ADDR_HI = 7'h3D;
   localparam int CTRL_CONT_BIT = 7;
   localparam int CTRL_DC_BIT = 6;
   // ==========================================================
   // Command values
   localparam logic [7:0] CMD_CONTRAST = 8'h81;
   localparam logic [7:0] CMD_DISPLAY_OFF = 8'h08;
   localparam logic [7:0] CMD_DISPLAY_ON = 8'h0C;
   localparam logic [7:0] CONTRAST_RST = 8'h7F;
   localparam logic [7:0] CONTRAST_NONE = 8'h00;
   // ==========================================================
   // Display RAM and byte buffer
   localparam int COL_W = 7;
   localparam int RAM_DEPTH = 128;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
   // ==========================================================
   // Link timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int LINK_QTR_NS = 80;
   localparam int LINK_QTR_CYC = (LINK_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================================
   // Controller registers
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam int CMD_START_BIT = 8;
   localparam int CMD_STOP_BIT = 9;
   localparam int CMD_READ_BIT = 10;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;
endpackage

// ### rtl/ocp_if.sv
// Two-wire link between the controller and the display port.
// Assumes both ends only pull lines low; the wires resolve here.
`timescale 1ns/1ps
`default_nettype none
interface ocp_if;
   // Pull-down enables of each end
   logic scl_h_oe;
   logic sda_h_oe;
   logic scl_d_oe;
   logic sda_d_oe;
   // Chip select, driven by the controller
   logic cs_n;
   // Resolved wire levels
   logic scl;
   logic sda;
   // Wired-AND with pull-ups, data in and out joined
   assign scl = ~(scl_h_oe | scl_d_oe); // R11
   assign sda = ~(sda_h_oe | sda_d_oe); // R11
   modport host (input scl, input sda, output scl_h_oe, output sda_h_oe, output cs_n);
   modport dev (input scl, input sda, input cs_n, output scl_d_oe, output sda_d_oe);
endinterface
`default_nettype wire

// ### rtl/ocp_host.sv
// Link controller: software issues bytes through classic Wishbone.
// Assumes the link clock is made here and may be stretched by the port.
`timescale 1ns/1ps
`default_nettype none
module ocp_host (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Two-wire link
   ocp_if.host link
);
   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} ocp_host_state_t;

   ocp_host_state_t st_q, st_d;
   logic [1:0] ph_q, ph_d;
   logic [3:0] tmr_q, tmr_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] txb_q, txb_d;
   logic [7:0] rx_q, rx_d;
   logic start_q, start_d, stop_q, stop_d, read_q, read_d, nack_q, nack_d;
   logic sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic cs_n_q;
   logic [1:0] meta_q, sync_q;
   logic scl_s, sda_s, adv, cmd_wr, enter;

   // ==========================================================
   // Outputs
   assign wb_dat_o = dat_q;
   assign wb_ack_o = ack_q;
   assign link.scl_h_oe = scl_oe_q;
   assign link.sda_h_oe = sda_oe_q;
   assign link.cs_n = cs_n_q; // R10
   assign scl_s = sync_q[0];
   assign sda_s = sync_q[1];

   // ==========================================================
   // Bus answer and command decode
   assign cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && (wb_adr_i == ocp_pkg::REG_CMD)
      && (wb_sel_i[1:0] == 2'h3) && (st_q == H_IDLE);
   assign adv = (tmr_q == 4'(ocp_pkg::LINK_QTR_CYC - 1)) && ((ph_q != 2'h1) || scl_s);
   assign enter = cmd_wr || ((st_q != H_IDLE) && adv);

   // Next state of bus slave and link sequencer
   always_comb
   begin
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      dat_d = dat_q;
      if (wb_cyc_i && wb_stb_i && !ack_q)
      begin
         dat_d = 32'h0;
         if (wb_adr_i == ocp_pkg::REG_STAT)
         begin
            dat_d[15:8] = rx_q;
            dat_d[ocp_pkg::STAT_NACK_BIT] = nack_q;
            dat_d[ocp_pkg::STAT_BUSY_BIT] = (st_q != H_IDLE);
         end
      end
      st_d = st_q;
      ph_d = ph_q;
      bit_d = bit_q;
      txb_d = txb_q;
      rx_d = rx_q;
      start_d = start_q;
      stop_d = stop_q;
      read_d = read_q;
      nack_d = nack_q;
      sda_oe_d = sda_oe_q;
      scl_oe_d = scl_oe_q;
      tmr_d = (tmr_q == 4'(ocp_pkg::LINK_QTR_CYC - 1)) ? tmr_q : tmr_q + 4'h1;
      if (cmd_wr)
      begin
         txb_d = wb_dat_i[7:0];
         start_d = wb_dat_i[ocp_pkg::CMD_START_BIT];
         stop_d = wb_dat_i[ocp_pkg::CMD_STOP_BIT];
         read_d = wb_dat_i[ocp_pkg::CMD_READ_BIT];
         nack_d = 1'h0;
         st_d = wb_dat_i[ocp_pkg::CMD_START_BIT] ? H_START : H_BIT;
         ph_d = 2'h0;
         bit_d = 4'h0;
         tmr_d = 4'h0;
      end
      else if (st_q != H_IDLE && adv)
      begin
         tmr_d = 4'h0;
         ph_d = ph_q + 2'h1;
         // Sample at the end of the high phase
         if (st_q == H_BIT && ph_q == 2'h2)
         begin
            if (bit_q != 4'h8)
               rx_d = {rx_q[6:0], sda_s};
            else if (!read_q)
               nack_d = sda_s;
         end
         if (ph_q == 2'h3)
         begin
            case (st_q)
               H_START: st_d = H_BIT;
               H_BIT:
               begin
                  txb_d = {txb_q[6:0], 1'h0};
                  bit_d = bit_q + 4'h1;
                  if (bit_q == 4'h8)
                     st_d = stop_q ? H_STOP : H_IDLE;
               end
               default: st_d = H_IDLE;
            endcase
         end
      end
      // Line drive on entering each quarter
      if (enter)
      begin
         case (st_d)
            H_START:
               case (ph_d)
                  2'h0: sda_oe_d = 1'h0;
                  2'h1: scl_oe_d = 1'h0;
                  2'h2: sda_oe_d = 1'h1;
                  default: scl_oe_d = 1'h1;
               endcase
            H_BIT:
               case (ph_d)
                  2'h0: sda_oe_d = (bit_d == 4'h8) ? (read_d && !stop_d) : (!read_d && !txb_d[7]);
                  2'h1: scl_oe_d = 1'h0;
                  2'h2: scl_oe_d = 1'h0;
                  default: scl_oe_d = 1'h1;
               endcase
            H_STOP:
               case (ph_d)
                  2'h0: sda_oe_d = 1'h1;
                  2'h1: scl_oe_d = 1'h0;
                  2'h2: sda_oe_d = 1'h0;
                  default: sda_oe_d = 1'h0;
               endcase
            default: sda_oe_d = 1'h0;
         endcase
      end
   end

   // Registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= H_IDLE;
         ph_q <= 2'h0;
         tmr_q <= 4'h0;
         bit_q <= 4'h0;
         txb_q <= 8'h00;
         rx_q <= 8'h00;
         start_q <= 1'h0;
         stop_q <= 1'h0;
         read_q <= 1'h0;
         nack_q <= 1'h0;
         sda_oe_q <= 1'h0;
         scl_oe_q <= 1'h0;
         ack_q <= 1'h0;
         dat_q <= 32'h0;
         cs_n_q <= 1'h0;
         meta_q <= 2'h3;
         sync_q <= 2'h3;
      end
      else if (ce_i)
      begin
         st_q <= st_d;
         ph_q <= ph_d;
         tmr_q <= tmr_d;
         bit_q <= bit_d;
         txb_q <= txb_d;
         rx_q <= rx_d;
         start_q <= start_d;
         stop_q <= stop_d;
         read_q <= read_d;
         nack_q <= nack_d;
         sda_oe_q <= sda_oe_d;
         scl_oe_q <= scl_oe_d;
         ack_q <= ack_d;
         dat_q <= dat_d;
         cs_n_q <= 1'h0; // R10
         meta_q <= {link.sda, link.scl};
         sync_q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ### rtl/ocp_dev.sv
// Two-wire target port of a character display controller.
// Assumes the controller makes the link clock and honours stretching.
// Notes on behaviour
// R1 - Match address byte before accepting more bytes
// R2 - Address 0111100 or 0111101 by strap
// R3 - Direction bit one reads, zero writes
// R4 - Control byte: continuation, select, six zeros
// R5 - Continuation zero: all later bytes are data
// R6 - Select zero commands, one into display RAM
// R7 - Column pointer advances after each RAM write
// R8 - Contrast command takes step 01h to FFh
// R9 - Host starts display off, ends display on
// R10 - Chip select held low in two-wire mode
// R11 - Data in and out joined as one line
// R12 - Acknowledge matching address and written bytes
// R13 - Continuation one: one byte, then control
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module ocp_dev (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Address strap pin
   input wire logic address_strap_bit_i,
   // Command stream to the decoder
   input wire logic cmd_ready_i,
   output logic cmd_valid_o,
   output logic [7:0] cmd_byte_o,
   // Display state
   output logic [7:0] contrast_o,
   output logic [6:0] col_o,
   input wire logic [6:0] rd_addr_i,
   output logic [7:0] rd_data_o,
   // Two-wire link
   ocp_if.dev link
);
   typedef enum logic [2:0] {S_IDLE, S_RX, S_BYTE, S_ACK, S_STALL, S_TX, S_TXACK, S_TXNEXT}
      ocp_dev_state_t;

   ocp_dev_state_t st_q, st_d;
   logic [2:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   logic is_addr_q, is_addr_d, rd_q, rd_d;
   logic exp_ctrl_q, exp_ctrl_d, cont_q, cont_d, dc_q, dc_d;
   logic sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
   logic [3:0] meta_q, sync_q;
   logic scl_p_q, sda_p_q;
   logic scl_s, sda_s, strap_s, cs_n_s;
   logic rise, fall, start, stop;
   logic [6:0] own_addr;
   logic [7:0] status;
   // Byte buffer
   logic [8:0] fifo_mem [2];
   logic wp_q, wp_d, rp_q, rp_d;
   logic [1:0] fcnt_q, fcnt_d;
   logic push, pop, fifo_rdy;
   logic [8:0] head;
   // Consumer side
   logic [7:0] display_data_ram [ocp_pkg::RAM_DEPTH];
   logic [6:0] col_q, col_d;
   logic [7:0] ctr_q, ctr_d;
   logic pend_q, pend_d;
   logic cmdv_q, cmdv_d;
   logic [7:0] cmdb_q, cmdb_d;
   logic ram_we;
   logic [7:0] rd_data_q;

   // ==========================================================
   // Outputs and edge detection
   assign link.scl_d_oe = scl_oe_q;
   assign link.sda_d_oe = sda_oe_q;
   assign cmd_valid_o = cmdv_q;
   assign cmd_byte_o = cmdb_q;
   assign contrast_o = ctr_q;
   assign col_o = col_q;
   assign rd_data_o = rd_data_q;
   assign scl_s = sync_q[0];
   assign sda_s = sync_q[1];
   assign strap_s = sync_q[2];
   assign cs_n_s = sync_q[3];
   assign rise = scl_s && !scl_p_q;
   assign fall = !scl_s && scl_p_q;
   assign start = scl_s && scl_p_q && sda_p_q && !sda_s;
   assign stop = scl_s && scl_p_q && !sda_p_q && sda_s;
   assign own_addr = strap_s ? ocp_pkg::TGT_ADDR_HI : ocp_pkg::TGT_ADDR_LO; // R2
   assign status = {fcnt_q != 2'h0, col_q};
   assign fifo_rdy = (fcnt_q != ocp_pkg::FIFO_DEPTH);
   assign head = fifo_mem[rp_q];

   // Link byte engine
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      is_addr_d = is_addr_q;
      rd_d = rd_q;
      exp_ctrl_d = exp_ctrl_q;
      cont_d = cont_q;
      dc_d = dc_q;
      sda_oe_d = sda_oe_q;
      scl_oe_d = scl_oe_q;
      push = 1'h0;
      if (cs_n_s || stop)
      begin
         st_d = S_IDLE;
         sda_oe_d = 1'h0;
         scl_oe_d = 1'h0;
      end
      else if (start && !sda_oe_q)
      begin
         st_d = S_RX;
         cnt_d = 3'h0;
         is_addr_d = 1'h1;
         sda_oe_d = 1'h0;
         scl_oe_d = 1'h0;
      end
      else
      begin
         case (st_q)
            S_RX:
               if (rise)
               begin
                  sh_d = {sh_q[6:0], sda_s};
                  cnt_d = cnt_q + 3'h1;
                  if (cnt_q == 3'h7)
                     st_d = S_BYTE;
               end
            S_BYTE:
               if (fall)
               begin
                  if (is_addr_q)
                  begin
                     if (sh_q[7:1] == own_addr) // R1
                     begin
                        st_d = S_ACK;
                        sda_oe_d = 1'h1; // R12
                        rd_d = sh_q[0]; // R3
                        exp_ctrl_d = 1'h1; // R4
                     end
                     else
                        st_d = S_IDLE; // R12
                  end
                  else if (exp_ctrl_q)
                  begin
                     cont_d = sh_q[ocp_pkg::CTRL_CONT_BIT]; // R4
                     dc_d = sh_q[ocp_pkg::CTRL_DC_BIT]; // R6
                     exp_ctrl_d = 1'h0;
                     st_d = S_ACK;
                     sda_oe_d = 1'h1; // R12
                  end
                  else if (fifo_rdy)
                  begin
                     push = 1'h1;
                     exp_ctrl_d = cont_q; // R5 R13
                     st_d = S_ACK;
                     sda_oe_d = 1'h1; // R12
                  end
                  else
                  begin
                     st_d = S_STALL;
                     scl_oe_d = 1'h1;
                  end
               end
            // Ack goes low while clock is held; clock freed a cycle later
            S_STALL:
               if (sda_oe_q)
               begin
                  scl_oe_d = 1'h0;
                  st_d = S_ACK;
               end
               else if (fifo_rdy)
               begin
                  push = 1'h1;
                  exp_ctrl_d = cont_q; // R5 R13
                  sda_oe_d = 1'h1; // R12
               end
            S_ACK:
               if (fall)
               begin
                  is_addr_d = 1'h0;
                  cnt_d = 3'h0;
                  if (is_addr_q && rd_q) // R3
                  begin
                     sh_d = status;
                     sda_oe_d = !status[7];
                     st_d = S_TX;
                  end
                  else
                  begin
                     sda_oe_d = 1'h0;
                     st_d = S_RX;
                  end
               end
            S_TX:
               if (fall)
               begin
                  if (cnt_q == 3'h7)
                  begin
                     sda_oe_d = 1'h0;
                     st_d = S_TXACK;
                  end
                  else
                  begin
                     sh_d = {sh_q[6:0], 1'h0};
                     cnt_d = cnt_q + 3'h1;
                     sda_oe_d = !sh_q[6];
                  end
               end
            S_TXACK:
               if (rise)
                  st_d = sda_s ? S_IDLE : S_TXNEXT;
            S_TXNEXT:
               if (fall)
               begin
                  sh_d = status;
                  cnt_d = 3'h0;
                  sda_oe_d = !status[7];
                  st_d = S_TX;
               end
            default: st_d = S_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Buffer drain: display RAM, contrast and command stream
   always_comb
   begin
      pop = 1'h0;
      ram_we = 1'h0;
      col_d = col_q;
      ctr_d = ctr_q;
      pend_d = pend_q;
      cmdv_d = cmdv_q && !cmd_ready_i;
      cmdb_d = cmdb_q;
      if (fcnt_q != 2'h0)
      begin
         if (head[8]) // R6
         begin
            ram_we = 1'h1;
            col_d = col_q + 7'h01; // R7
            pop = 1'h1;
         end
         else if (!cmdv_q || cmd_ready_i)
         begin
            pop = 1'h1;
            cmdv_d = 1'h1; // R6
            cmdb_d = head[7:0];
            if (pend_q)
            begin
               pend_d = 1'h0;
               if (head[7:0] != ocp_pkg::CONTRAST_NONE)
                  ctr_d = head[7:0]; // R8
            end
            else if (head[7:0] == ocp_pkg::CMD_CONTRAST)
               pend_d = 1'h1; // R8
         end
      end
      fcnt_d = fcnt_q + {1'h0, push} - {1'h0, pop};
      wp_d = wp_q ^ push;
      rp_d = rp_q ^ pop;
   end

   // Registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= S_IDLE;
         cnt_q <= 3'h0;
         sh_q <= 8'h00;
         is_addr_q <= 1'h0;
         rd_q <= 1'h0;
         exp_ctrl_q <= 1'h1;
         cont_q <= 1'h0;
         dc_q <= 1'h0;
         sda_oe_q <= 1'h0;
         scl_oe_q <= 1'h0;
         meta_q <= 4'h3;
         sync_q <= 4'h3;
         scl_p_q <= 1'h1;
         sda_p_q <= 1'h1;
         wp_q <= 1'h0;
         rp_q <= 1'h0;
         fcnt_q <= 2'h0;
         col_q <= 7'h00;
         ctr_q <= ocp_pkg::CONTRAST_RST;
         pend_q <= 1'h0;
         cmdv_q <= 1'h0;
         cmdb_q <= 8'h00;
         rd_data_q <= 8'h00;
      end
      else if (ce_i)
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         is_addr_q <= is_addr_d;
         rd_q <= rd_d;
         exp_ctrl_q <= exp_ctrl_d;
         cont_q <= cont_d;
         dc_q <= dc_d;
         sda_oe_q <= sda_oe_d;
         scl_oe_q <= scl_oe_d;
         meta_q <= {link.cs_n, address_strap_bit_i, link.sda, link.scl};
         sync_q <= meta_q;
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
         wp_q <= wp_d;
         rp_q <= rp_d;
         fcnt_q <= fcnt_d;
         col_q <= col_d;
         ctr_q <= ctr_d;
         pend_q <= pend_d;
         cmdv_q <= cmdv_d;
         cmdb_q <= cmdb_d;
         rd_data_q <= display_data_ram[rd_addr_i];
      end
   end

   // Buffer and display RAM storage
   always_ff @(posedge clk_i)
   begin
      if (ce_i && push)
         fifo_mem[wp_q] <= {dc_q, sh_q};
      if (ce_i && ram_we)
         display_data_ram[col_q] <= head[7:0];
   end
endmodule
`default_nettype wire

// ### testbench/ocp_link_sva.sv
// Checker for the two-wire link between the controller and the display port.
// Assumes it is instantiated beside the interface in the bench top.
`timescale 1ns/1ps
`default_nettype none
module ocp_link_sva (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Link signals
   input wire logic scl_h_oe,
   input wire logic sda_h_oe,
   input wire logic scl_d_oe,
   input wire logic sda_d_oe,
   input wire logic cs_n,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // Frame tracking
   logic scl_q, sda_q, idle_q, idle_d, far_q, far_d;
   logic [3:0] cnt_q, cnt_d;
   logic [6:0] sh_q, sh_d;
   // Next state: start, stop and first byte of a frame
   always_comb
   begin
      idle_d = idle_q;
      far_d = far_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      if (scl && !scl_q && cnt_q < 4'h8)
      begin
         cnt_d = cnt_q + 4'h1;
         sh_d = {sh_q[5:0], sda};
         far_d = (cnt_q == 4'h7) && (sh_q[6:1] != 6'h1E);
      end
      if (scl && scl_q && sda_q && !sda)
      begin
         idle_d = 1'b0;
         far_d = 1'b0;
         cnt_d = 4'h0;
      end
      if (scl && scl_q && !sda_q && sda)
         idle_d = 1'b1;
   end
   // Registers of the tracker
   always_ff @(posedge clk_i)
   begin
      scl_q <= scl;
      sda_q <= sda;
      sh_q <= sh_d;
      idle_q <= rst_i | idle_d;
      far_q <= !rst_i & far_d;
      cnt_q <= rst_i ? 4'h8 : cnt_d;
   end
   // ==========================================================
   // Properties
   sequence s_scl_rise;
      !scl ##1 scl;
   endsequence
   AST_CS_LOW:
      assert property (cs_n == 1'b0) else $error("chip select left high");
   AST_SCL_WIRED:
      assert property (scl == !(scl_h_oe || scl_d_oe)) else $error("clock line level wrong");
   AST_SDA_WIRED:
      assert property (sda == !(sda_h_oe || sda_d_oe)) else $error("data line level wrong");
   AST_REL_AFTER_RST:
      assert property ($past(rst_i) |-> !(sda_d_oe || scl_d_oe || sda_h_oe || scl_h_oe))
         else $error("line held after reset");
   AST_FAR_SILENT:
      assert property (far_q |-> !sda_d_oe) else $error("port answered a foreign address");
   AST_IDLE_SILENT:
      assert property (idle_q |-> !sda_d_oe) else $error("port drove data outside a frame");
   AST_DEV_SDA_LOW_PHASE:
      assert property ($changed(sda_d_oe) |-> !scl) else $error("port moved data in clock high");
   AST_DEV_HOLD_HIGH:
      assert property (s_scl_rise |=> $stable(sda_d_oe)[*4]) else $error("port data not held");
endmodule
`default_nettype wire

// ### testbench/oled_char_i2c_host_port_tb.sv
// Bench for the two-wire display port: controller, port and link checker.
// Assumes the controller and port from rtl/ and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module oled_char_i2c_host_port_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_we = 1'b0;
   logic [3:0] wb_adr = 4'h0;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_rdat, s;
   logic wb_ack, strap = 1'b0, cmd_ready = 1'b0, cmd_valid, hold = 1'b0;
   logic [7:0] cmd_byte, contrast, rd_data;
   logic [6:0] col, rd_addr = 7'h0;
   logic [8:0] mon_q = 9'h0, snap = 9'h0;
   logic scl_q = 1'b1, sda_q = 1'b1;
   int n_fail = 0, check_count = 0, cycles = 0, nbit = 0;
   int col_m = 0, contrast_m = ocp_pkg::CONTRAST_RST, arm = 0;
   int ram_m [128];
   bit ram_w [128];
   int exp_cmd [$], pl [$];
   ocp_if link ();
   ocp_host u_ocp_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_cyc), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
      .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(link.host));
   ocp_dev u_ocp_dev (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .address_strap_bit_i(strap),
      .cmd_ready_i(cmd_ready), .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte),
      .contrast_o(contrast), .col_o(col), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
      .link(link.dev));
   ocp_link_sva u_ocp_link_sva (.clk_i(clk_i), .rst_i(rst_i), .scl_h_oe(link.scl_h_oe),
      .sda_h_oe(link.sda_h_oe), .scl_d_oe(link.scl_d_oe), .sda_d_oe(link.sda_d_oe),
      .cs_n(link.cs_n), .scl(link.scl), .sda(link.sda));
   // Clock
   initial
   begin
      forever #5 clk_i = ~clk_i;
   end
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // One classic Wishbone cycle, entered just after a rising edge
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      wb_cyc <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat <= d;
      @(posedge clk_i);
      while (wb_ack !== 1'b1)
         @(posedge clk_i);
      s = wb_rdat;
      wb_cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   // Issue one byte command and poll until idle
   task automatic send(input logic [10:0] c);
      wb(1'b1, ocp_pkg::REG_CMD, {21'h0, c});
      s = 32'h1;
      while (s[ocp_pkg::STAT_BUSY_BIT] !== 1'b0)
         wb(1'b0, ocp_pkg::REG_STAT, 32'h0);
   endtask
   // Write frame of pl bytes; model updated before each byte goes out
   task automatic frame(input logic [7:0] a, input logic ok);
      int st;
      int sel;
      st = 0;
      sel = 0;
      send({1'b0, pl.size() == 0, 1'b1, a});
      chk("addr_wire", {a, !ok}, snap);
      chk("addr_nack", !ok, s[ocp_pkg::STAT_NACK_BIT]);
      foreach (pl[i])
      begin
         if (st == 0)
         begin
            sel = pl[i][6];
            st = pl[i][7] ? 1 : 2;
         end
         else
         begin
            st = (st == 1) ? 0 : st;
            if (sel != 0)
            begin
               ram_m[col_m] = pl[i];
               ram_w[col_m] = 1'b1;
               col_m = (col_m + 1) % 128;
            end
            else
            begin
               exp_cmd.push_back(pl[i]);
               contrast_m = (arm != 0 && pl[i] != 0) ? pl[i] : contrast_m;
               arm = (arm == 0 && pl[i] == ocp_pkg::CMD_CONTRAST);
            end
         end
         send({1'b0, i == pl.size() - 1, 1'b0, pl[i][7:0]});
         chk("byte_wire", {pl[i][7:0], 1'b0}, snap);
      end
   endtask
   // Drain the command stream, then compare display state
   task automatic settle();
      for (int t = 0; t < 5000 && exp_cmd.size() > 0; t++)
         @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      chk("cmd_left", 0, exp_cmd.size());
      chk("contrast", contrast_m, contrast);
      chk("column", col_m, col);
      for (int i = 0; i < 128; i++)
      begin
         if (ram_w[i])
         begin
            rd_addr <= i[6:0];
            repeat (2) @(posedge clk_i);
            chk("ram", ram_m[i], rd_data);
         end
      end
   endtask
   // ==========================================================
   // Timeout, wire monitor and command consumer
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      scl_q <= link.scl;
      sda_q <= link.sda;
      if (link.scl && scl_q && sda_q && !link.sda)
         nbit <= 0;
      else if (link.scl && !scl_q)
      begin
         mon_q <= {mon_q[7:0], link.sda};
         nbit <= (nbit == 8) ? 0 : nbit + 1;
         if (nbit == 8)
            snap <= {mon_q[7:0], link.sda};
      end
      if (cmd_valid === 1'b1 && cmd_ready)
         chk("cmd_byte", exp_cmd.size() > 0 ? exp_cmd.pop_front() : 32'h100, cmd_byte);
      cmd_ready <= !hold && ($urandom % 3 != 0);
      // Timeout ends the run last in this process
      if (cycles == 40000)
      begin
         n_fail++;
         report_and_stop();
      end
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      void'($urandom(32'h27A9));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      settle();
      chk("cs_n", 1'b0, link.cs_n);
      frame(8'hA0, 1'b0);
      frame(8'h7A, 1'b0);
      pl = '{8'h00, ocp_pkg::CMD_DISPLAY_OFF, ocp_pkg::CMD_CONTRAST, 1 + $urandom % 255,
         ocp_pkg::CMD_CONTRAST, 8'h00, ocp_pkg::CMD_DISPLAY_ON};
      hold <= 1'b1;
      fork
         begin
            repeat (3000) @(posedge clk_i);
            hold <= 1'b0;
         end
      join_none
      frame(8'h78, 1'b1);
      settle();
      pl = '{8'h80, 8'hA5, 8'hC0, $urandom % 256, 8'h80, 8'h5A, 8'h40, 8'h11, 8'hEE};
      frame(8'h78, 1'b1);
      settle();
      strap <= 1'b1;
      repeat (4) @(posedge clk_i);
      pl = '{8'h40};
      repeat (6) pl.push_back($urandom % 256);
      frame(8'h7A, 1'b1);
      pl.delete();
      frame(8'h78, 1'b0);
      settle();
      send(11'h17B);
      send(11'h600);
      chk("read_byte", {1'b0, col_m[6:0]}, s[15:8]);
      chk("read_wire", {1'b0, col_m[6:0], 1'b1}, snap);
      report_and_stop();
   end
endmodule
`default_nettype wire
